// file: hdl/sfg_pkg.sv
//**********************************************************************
// Purpose: Constants and types for the flash section guard
// Assumes: 32-bit Avalon-MM slave, byte addresses
// Notes:   Lock fields hold one bit each, 1 = unprogrammed
//**********************************************************************
package sfg_pkg;

    localparam int ADDR_W = 15;
    localparam int BUS_AW = 4;
    localparam int EV_W   = 3;

    // ******************************************************************
    // Register byte offsets
    // ******************************************************************
    localparam logic [BUS_AW-1:0] REG_CTRL     = 4'h0;
    localparam logic [BUS_AW-1:0] REG_STATUS   = 4'h4;
    localparam logic [BUS_AW-1:0] REG_IRQ_STAT = 4'h8;
    localparam logic [BUS_AW-1:0] REG_IRQ_MASK = 4'hC;

    // ******************************************************************
    // Field positions
    // ******************************************************************
    localparam int CTRL_CLR_BUSY = 0;
    localparam int STAT_BUSY     = 0;
    localparam int STAT_RWW_OP   = 1;
    localparam int STAT_HALT_OP  = 2;
    localparam int STAT_LOCK_LSB = 4;
    localparam int LK_APP_LOW    = 0;
    localparam int LK_APP_HIGH   = 1;
    localparam int LK_LDR_LOW    = 2;
    localparam int LK_LDR_HIGH   = 3;
    localparam int EV_DONE       = 0;
    localparam int EV_STORE_REF  = 1;
    localparam int EV_LOAD_REF   = 2;

    localparam logic [3:0]  LOCK_UNPROG = 4'hF;
    localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE      = 2'b00,
        ST_PROG_RWW  = 2'b01,
        ST_PROG_HALT = 2'b10
    } sfg_state_t;

    typedef enum logic [1:0] {
        SK_BUFFER  = 2'b00,
        SK_ERASE   = 2'b01,
        SK_WRITE   = 2'b10,
        SK_LOCKSET = 2'b11
    } sfg_kind_t;

endpackage : sfg_pkg

// file: hdl/sfg_guard.sv
//**********************************************************************
// Purpose: Section guard and stall control for flash self-programming
// Assumes: Core requests are one-cycle pulses on sys_clk
// Notes:   Fuse pins are synchronised; lock bits clear only on erase or reset
//**********************************************************************
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns

module sfg_guard
    import sfg_pkg::*;
#(
    parameter int                FLASH_WORDS = 32768,
    parameter logic [ADDR_W-1:0] HALT_START  = 15'h7000,
    parameter int                LDR_SIZE0   = 4096,
    parameter int                LDR_SIZE1   = 2048,
    parameter int                LDR_SIZE2   = 1024,
    parameter int                LDR_SIZE3   = 512,
    parameter int                PROG_CYCLES = 16,
    parameter int                CNT_W       = 16
) (
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic [BUS_AW-1:0] avsAddress,
    input  wire logic              avsRead,
    input  wire logic              avsWrite,
    input  wire logic [31:0]       avsWriteData,
    output logic      [31:0]       avsReadData,
    output logic                   avsWaitRequest,
    output logic                   irq,
    input  wire logic [1:0]        loaderSizeFuses,
    input  wire logic              storeReq,
    input  wire logic [1:0]        storeKind,
    input  wire logic [ADDR_W-1:0] storePc,
    input  wire logic [ADDR_W-1:0] storeAddr,
    input  wire logic [3:0]        storeLockData,
    output logic                   storeAccept,
    output logic                   storeRefuse,
    input  wire logic              loadReq,
    input  wire logic [ADDR_W-1:0] loadPc,
    input  wire logic [ADDR_W-1:0] loadAddr,
    output logic                   loadGrant,
    output logic                   loadRefuse,
    input  wire logic [ADDR_W-1:0] execPc,
    input  wire logic              vecInLoader,
    output logic                   intSuppress,
    input  wire logic              progLockWe,
    input  wire logic [3:0]        progLockData,
    input  wire logic              chipErase,
    output logic                   flashEraseGo,
    output logic                   flashWriteGo,
    output logic      [ADDR_W-1:0] flashOpAddr,
    output logic                   coreStall,
    output logic                   rwwBlocked
);

    // ******************************************************************
    // State
    // ******************************************************************
    typedef struct packed {
        sfg_state_t        st;
        logic [CNT_W-1:0]  cnt;
        logic              busy;
        logic [ADDR_W-1:0] opAddr;
        logic [3:0]        lock;
        logic [1:0]        fuseMeta;
        logic [1:0]        fuseSync;
        logic [EV_W-1:0]   irqStat;
        logic [EV_W-1:0]   irqMask;
        logic [31:0]       rdData;
        logic              pend;
        logic              storeOk;
        logic              storeRef;
        logic              loadOk;
        logic              loadRef;
        logic              eraseGo;
        logic              writeGo;
    } sfg_regs_t;

    sfg_regs_t r_reg;
    sfg_regs_t r_next;

    // ******************************************************************
    // Section decode
    // ******************************************************************
    // Border sits at the top of flash; a wider fuse code shrinks it
    function automatic logic [ADDR_W:0] ldrBase(
        input logic [1:0] f
    );
        int sz;
        unique case (f)
            2'b00:   sz = LDR_SIZE0;
            2'b01:   sz = LDR_SIZE1;
            2'b10:   sz = LDR_SIZE2;
            default: sz = LDR_SIZE3;
        endcase
        return (ADDR_W+1)'(FLASH_WORDS - sz);
    endfunction : ldrBase

    function automatic logic inLdr(
        input logic [ADDR_W-1:0] a,
        input logic [1:0]        f
    );
        return {1'b0, a} >= ldrBase(f);
    endfunction : inLdr

    // Loader sizes never exceed the halting part, so it nests inside
    function automatic logic inHalt(
        input logic [ADDR_W-1:0] a
    );
        return a >= HALT_START;
    endfunction : inHalt

    logic fuseIdle;
    logic sFromLdr;
    logic sTgtLdr;
    logic sLocked;
    logic sGo;
    logic lFromLdr;
    logic lTgtLdr;
    logic lLockRef;
    logic lBlockRef;
    logic busAct;

    always_comb begin
        fuseIdle  = r_reg.st == ST_IDLE;
        sFromLdr  = inLdr(storePc, r_reg.fuseSync);
        sTgtLdr   = inLdr(storeAddr, r_reg.fuseSync);
        // Mode 2 and 3 of each pair have the low bit programmed
        sLocked   = sTgtLdr ? ~r_reg.lock[LK_LDR_LOW]
                            : ~r_reg.lock[LK_APP_LOW];
        // No general lock term here by design
        sGo = storeReq && fuseIdle && sFromLdr
            && (storeKind == SK_BUFFER
                || storeKind == SK_LOCKSET
                || !sLocked);
        lFromLdr  = inLdr(loadPc, r_reg.fuseSync);
        lTgtLdr   = inLdr(loadAddr, r_reg.fuseSync);
        lLockRef  = (lFromLdr && !lTgtLdr
                     && !r_reg.lock[LK_APP_HIGH])
                 || (!lFromLdr && lTgtLdr
                     && !r_reg.lock[LK_LDR_HIGH]);
        // Refusal guards the core even if software strays into it
        lBlockRef = r_reg.st == ST_PROG_HALT
                 || (r_reg.busy && !inHalt(loadAddr));
        busAct    = avsRead || avsWrite;
    end

    // ******************************************************************
    // Next state
    // ******************************************************************
    always_comb begin
        logic [31:0]     rd;
        logic [EV_W-1:0] ev;
        logic            clrBusy;
        rd      = RD_ZERO;
        ev      = '0;
        clrBusy = 1'b0;
        r_next  = r_reg;
        r_next.fuseMeta = loaderSizeFuses;
        r_next.fuseSync = r_reg.fuseMeta;
        r_next.storeOk  = 1'b0;
        r_next.storeRef = 1'b0;
        r_next.loadOk   = 1'b0;
        r_next.loadRef  = 1'b0;
        r_next.eraseGo  = 1'b0;
        r_next.writeGo  = 1'b0;

        // Two-cycle slave: data latched first, handed over second
        if (busAct && !r_reg.pend) begin
            r_next.pend = 1'b1;
            unique case (avsAddress)
                REG_STATUS: begin
                    rd[STAT_BUSY]    = r_reg.busy;
                    rd[STAT_RWW_OP]  = r_reg.st == ST_PROG_RWW;
                    rd[STAT_HALT_OP] = r_reg.st == ST_PROG_HALT;
                    rd[STAT_LOCK_LSB +: 4] = r_reg.lock;
                end
                REG_IRQ_STAT: rd[EV_W-1:0] = r_reg.irqStat;
                REG_IRQ_MASK: rd[EV_W-1:0] = r_reg.irqMask;
                default:      rd = RD_ZERO;
            endcase
            r_next.rdData = rd;
        end else begin
            r_next.pend = 1'b0;
        end

        if (r_reg.pend && avsWrite) begin
            unique case (avsAddress)
                REG_CTRL:
                    clrBusy = avsWriteData[CTRL_CLR_BUSY];
                REG_IRQ_MASK:
                    r_next.irqMask = avsWriteData[EV_W-1:0];
                default: ;
            endcase
        end

        // Re-enable is ignored while an operation still runs
        if (clrBusy && fuseIdle)
            r_next.busy = 1'b0;

        // Programming countdown
        if (!fuseIdle) begin
            if (r_reg.cnt == '0) begin
                r_next.st   = ST_IDLE;
                ev[EV_DONE] = 1'b1;
            end else begin
                r_next.cnt = r_reg.cnt - CNT_W'(1);
            end
        end

        // Store handling
        if (sGo) begin
            r_next.storeOk = 1'b1;
            unique case (storeKind)
                SK_BUFFER: r_next.busy = 1'b0;
                SK_LOCKSET:
                    r_next.lock = r_reg.lock & storeLockData;
                default: begin
                    r_next.opAddr  = storeAddr;
                    r_next.cnt     = CNT_W'(PROG_CYCLES - 1);
                    r_next.eraseGo = storeKind == SK_ERASE;
                    r_next.writeGo = storeKind == SK_WRITE;
                    if (inHalt(storeAddr)) begin
                        r_next.st = ST_PROG_HALT;
                    end else begin
                        r_next.st   = ST_PROG_RWW;
                        r_next.busy = 1'b1;
                    end
                end
            endcase
        end else if (storeReq) begin
            r_next.storeRef    = 1'b1;
            ev[EV_STORE_REF]   = 1'b1;
        end

        // Load handling
        if (loadReq) begin
            if (lLockRef || lBlockRef) begin
                r_next.loadRef   = 1'b1;
                ev[EV_LOAD_REF]  = 1'b1;
            end else begin
                r_next.loadOk = 1'b1;
            end
        end

        if (progLockWe)
            r_next.lock = r_next.lock & progLockData;
        if (chipErase)
            r_next.lock = LOCK_UNPROG;

        // Events win over a clear in the same cycle
        if (r_reg.pend && avsWrite && avsAddress == REG_IRQ_STAT)
            r_next.irqStat = r_reg.irqStat & ~avsWriteData[EV_W-1:0];
        r_next.irqStat = r_next.irqStat | ev;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            r_reg <= '{st: ST_IDLE, lock: LOCK_UNPROG, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    // ******************************************************************
    // Outputs
    // ******************************************************************
    assign avsWaitRequest = busAct && !r_reg.pend;
    assign avsReadData    = r_reg.rdData;
    assign irq            = |(r_reg.irqStat & r_reg.irqMask);
    assign storeAccept    = r_reg.storeOk;
    assign storeRefuse    = r_reg.storeRef;
    assign loadGrant      = r_reg.loadOk;
    assign loadRefuse     = r_reg.loadRef;
    assign flashEraseGo   = r_reg.eraseGo;
    assign flashWriteGo   = r_reg.writeGo;
    assign flashOpAddr    = r_reg.opAddr;
    assign coreStall      = r_reg.st == ST_PROG_HALT;
    assign rwwBlocked     = r_reg.busy;
    assign intSuppress =
        (!r_reg.lock[LK_APP_HIGH] && vecInLoader
         && !inLdr(execPc, r_reg.fuseSync))
     || (!r_reg.lock[LK_LDR_HIGH] && !vecInLoader
         && inLdr(execPc, r_reg.fuseSync));

    // ******************************************************************
    // Checks
    // ******************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence sHaltGo;
        sGo && storeKind inside {SK_ERASE, SK_WRITE}
            && inHalt(storeAddr);
    endsequence
    // Busy may still stand from an earlier op; it must only hold here
    sequence sStallHeld;
        (coreStall && $stable(rwwBlocked)) [*4];
    endsequence
    sequence sRwwGo;
        sGo && storeKind == SK_ERASE && !inHalt(storeAddr);
    endsequence

    AST_APP_STORE_DEAD: assert property (
        storeReq && !sFromLdr |=> storeRefuse && !flashEraseGo
            && !flashWriteGo)
        else $error("store from application had effect");
    AST_HALT_STALL: assert property (
        sHaltGo |=> sStallHeld)
        else $error("core not stalled for halting op");
    AST_RWW_RUNS: assert property (
        sRwwGo |=> rwwBlocked && !coreStall && flashEraseGo)
        else $error("concurrent op wrong");
    AST_STALL_NO_LOAD: assert property (
        loadReq && coreStall |=> loadRefuse && !loadGrant)
        else $error("load granted during stall");
    AST_BUSY_HOLDS: assert property (
        rwwBlocked && fuseIdle && !avsWrite && !storeReq
            |=> rwwBlocked)
        else $error("busy flag dropped by itself");
    AST_APP_STORE_LOCK: assert property (
        storeReq && storeKind == SK_WRITE && !sTgtLdr
            && !r_reg.lock[LK_APP_LOW] |=> storeRefuse)
        else $error("locked app store accepted");
    AST_LDR_LOAD_LOCK: assert property (
        loadReq && !lFromLdr && lTgtLdr
            && !r_reg.lock[LK_LDR_HIGH] |=> loadRefuse)
        else $error("app read of locked loader");
    AST_LOCK_ONEWAY: assert property (
        !chipErase |=> (r_reg.lock & ~$past(r_reg.lock)) == '0)
        else $error("lock bit unprogrammed without erase");
    AST_REFUSE_QUIET: assert property (
        storeRefuse |-> !flashEraseGo && !flashWriteGo
            && (!$past(fuseIdle) || fuseIdle))
        else $error("refused store touched flash");

    AST_LDR_STORE_LOCK: assert property (
        storeReq && storeKind inside {SK_ERASE, SK_WRITE} && sTgtLdr
            && !r_reg.lock[LK_LDR_LOW] |=> storeRefuse)
        else $error("locked loader store accepted");
    AST_APP_LOAD_LOCK: assert property (
        loadReq && lFromLdr && !lTgtLdr
            && !r_reg.lock[LK_APP_HIGH] |=> loadRefuse)
        else $error("loader read of locked app");
    AST_BUSY_LOAD: assert property (
        loadReq && rwwBlocked && !inHalt(loadAddr) |=> loadRefuse)
        else $error("concurrent part read while busy");
    AST_RWW_LOAD_OK: assert property (
        loadReq && r_reg.st == ST_PROG_RWW && inHalt(loadAddr)
            && !lLockRef |=> loadGrant)
        else $error("halting part read refused during op");
    AST_STALL_ENDS: assert property (
        coreStall && r_reg.cnt == '0 |=> !coreStall)
        else $error("stall outlived the operation");

endmodule : sfg_guard

// file: tb/sfg_core_model.sv
//**************************************************************
// Purpose: Core model issuing store and load request pulses
// Assumes: Each pulse lasts one cycle, launched after a rising edge
// Notes:   Released address lines show inverted data, not stale
//**************************************************************
`timescale 1ns/1ns

module sfg_core_model
    import sfg_pkg::*;
(
    input  wire logic              sys_clk,
    output logic                   storeReq      = 1'b0,
    output logic      [1:0]        storeKind     = 2'h0,
    output logic      [ADDR_W-1:0] storePc       = 15'h0000,
    output logic      [ADDR_W-1:0] storeAddr     = 15'h0000,
    output logic      [3:0]        storeLockData = 4'hF,
    output logic                   loadReq       = 1'b0,
    output logic      [ADDR_W-1:0] loadPc        = 15'h0000,
    output logic      [ADDR_W-1:0] loadAddr      = 15'h0000
);
    // **********************************************************
    // Request tasks
    // **********************************************************
    task store(input logic [1:0] k, input logic [ADDR_W-1:0] pc,
               input logic [ADDR_W-1:0] a, input logic [3:0] d);
        @(posedge sys_clk);
        storeReq      <= 1'b1;
        storeKind     <= k;
        storePc       <= pc;
        storeAddr     <= a;
        storeLockData <= d;
        @(posedge sys_clk);
        storeReq      <= 1'b0;
        storePc       <= ~pc;
        storeAddr     <= ~a;
    endtask : store

    task load(input logic [ADDR_W-1:0] pc, input logic [ADDR_W-1:0] a);
        @(posedge sys_clk);
        loadReq  <= 1'b1;
        loadPc   <= pc;
        loadAddr <= a;
        @(posedge sys_clk);
        loadReq  <= 1'b0;
        loadPc   <= ~pc;
        loadAddr <= ~a;
    endtask : load
endmodule : sfg_core_model

// file: tb/tb_top.sv
//**************************************************************
// Purpose: Self-checking bench for the flash section guard
// Assumes: Fuses 00 put loader and halting part at 15'h7000 up
// Notes:   Short op length keeps the sixteen lock modes quick
//**************************************************************
`timescale 1ns/1ns

module tb_top
    import sfg_pkg::*;
;
    localparam int                PC = 8;
    localparam logic [ADDR_W-1:0] LP = 15'h7100;
    logic sys_clk = 1'b0, rstn = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
    logic [BUS_AW-1:0] avsAddress = 4'h0;
    logic [31:0] avsWriteData = 32'h0, avsReadData, q;
    logic avsWaitRequest, irq, storeReq, loadReq, vecInLoader = 1'b0;
    logic [1:0] loaderSizeFuses = 2'h0, storeKind;
    logic [ADDR_W-1:0] storePc, storeAddr, loadPc, loadAddr, flashOpAddr;
    logic [ADDR_W-1:0] execPc = 15'h0000;
    logic [3:0] storeLockData, progLockData = 4'hF, lk;
    logic storeAccept, storeRefuse, loadGrant, loadRefuse, intSuppress;
    logic progLockWe = 1'b0, chipErase = 1'b0, flashEraseGo;
    logic flashWriteGo, coreStall, rwwBlocked;
    logic [3:0] stQ[$];
    logic [1:0] ldQ[$];
    int nMismatch = 0, checkCount = 0;

    sfg_guard #(.PROG_CYCLES(PC)) uut (.*);
    sfg_core_model uCore (.sys_clk(sys_clk), .storeReq(storeReq),
        .storeKind(storeKind), .storePc(storePc), .storeAddr(storeAddr),
        .storeLockData(storeLockData), .loadReq(loadReq),
        .loadPc(loadPc), .loadAddr(loadAddr));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // **********************************************************
    // Shared tasks
    // **********************************************************
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checkCount++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            nMismatch++;
        end
    endtask : chk

    task report_and_stop;
        $display("checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop

    // Waits for waitrequest low, then takes data at that same edge
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        avsRead      <= !w;
        avsWrite     <= w;
        avsAddress   <= a;
        avsWriteData <= d;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 50);
        q = avsReadData;
        avsRead  <= 1'b0;
        avsWrite <= 1'b0;
        if (n >= 50) begin
            nMismatch++;
            report_and_stop;
        end
    endtask : bus

    task rd(input logic [3:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask : rd

    task st(input logic [1:0] k, input logic [ADDR_W-1:0] pc, a,
            input logic [3:0] d, input logic e);
        stQ.push_back({e, !e, e && k == SK_ERASE, e && k == SK_WRITE});
        uCore.store(k, pc, a, d);
    endtask : st

    task ld(input logic [ADDR_W-1:0] pc, a, input logic e);
        ldQ.push_back({e, !e});
        uCore.load(pc, a);
    endtask : ld

    // Erase puts every lock back to unprogrammed, then AND in d
    task lockw(input logic [3:0] d);
        @(posedge sys_clk);
        chipErase    <= 1'b1;
        @(posedge sys_clk);
        chipErase    <= 1'b0;
        progLockWe   <= 1'b1;
        progLockData <= d;
        @(posedge sys_clk);
        progLockWe   <= 1'b0;
        progLockData <= ~d;
    endtask : lockw

    task sup(input logic v, input logic [ADDR_W-1:0] pc, input logic e);
        @(posedge sys_clk);
        vecInLoader <= v;
        execPc      <= pc;
        @(negedge sys_clk);
        chk("intSuppress", e, intSuppress);
    endtask : sup

    function automatic logic [ADDR_W-1:0] rA();
        return ADDR_W'($urandom_range(32'h6FFF, 0));
    endfunction : rA

    function automatic logic [ADDR_W-1:0] rL();
        return 15'h7000 + ADDR_W'($urandom_range(32'hFFF, 0));
    endfunction : rL

    // **********************************************************
    // Result watcher
    // **********************************************************
    always @(posedge sys_clk) begin
        if (storeAccept || storeRefuse) begin
            if (stQ.size() == 0) chk("storeNote", 1, 0);
            else chk("store", stQ.pop_front(),
                     {storeAccept, storeRefuse, flashEraseGo, flashWriteGo});
        end
        if (loadGrant || loadRefuse) begin
            if (ldQ.size() == 0) chk("loadNote", 1, 0);
            else chk("load", ldQ.pop_front(), {loadGrant, loadRefuse});
        end
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        nMismatch++;
        report_and_stop;
    end

    // **********************************************************
    // Main sequence
    // **********************************************************
    initial begin
        void'($urandom(12));
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(REG_STATUS, 32'hF0, "status");
        bus(1'b1, REG_STATUS, 32'h0);
        rd(REG_STATUS, 32'hF0, "statusRo");
        rd(4'h2, 32'h0, "unmapped");
        $display("test registers done");
        st(SK_ERASE, LP, 15'h0100, 4'h0, 1'b1);
        @(negedge sys_clk);
        chk("rwwBlocked", 1, rwwBlocked);
        chk("coreStall", 0, coreStall);
        chk("opAddr", 32'h0100, flashOpAddr);
        ld(LP, 15'h7200, 1'b1);
        ld(LP, 15'h0100, 1'b0);
        st(SK_WRITE, LP, 15'h0200, 4'h0, 1'b0);
        repeat (PC) @(posedge sys_clk);
        rd(REG_STATUS, 32'hF1, "busyHeld");
        bus(1'b1, REG_CTRL, 32'h1);
        rd(REG_STATUS, 32'hF0, "busyClr");
        $display("test concurrent done");
        st(SK_WRITE, LP, 15'h7200, 4'h0, 1'b1);
        @(negedge sys_clk);
        chk("coreStall", 1, coreStall);
        chk("rwwBlocked", 0, rwwBlocked);
        ld(LP, 15'h7300, 1'b0);
        repeat (PC) @(posedge sys_clk);
        chk("stallEnd", 0, coreStall);
        $display("test halting done");
        st(SK_BUFFER, rA(), rL(), 4'h0, 1'b0);
        loaderSizeFuses <= 2'h3;
        repeat (4) @(posedge sys_clk);
        st(SK_BUFFER, LP, rA(), 4'h0, 1'b0);
        st(SK_BUFFER, 15'h7F00, rA(), 4'h0, 1'b1);
        loaderSizeFuses <= 2'h0;
        repeat (4) @(posedge sys_clk);
        $display("test sections done");
        for (int i = 0; i < 16; i++) begin
            lk = 4'(i);
            lockw(lk);
            rd(REG_STATUS, {24'h0, lk, 4'h0}, "locks");
            sup(1'b1, rA(), !lk[LK_APP_HIGH]);
            sup(1'b0, rL(), !lk[LK_LDR_HIGH]);
            ld(LP, rA(), lk[LK_APP_HIGH]);
            ld(rA(), rL(), lk[LK_LDR_HIGH]);
            st(SK_WRITE, LP, rA(), 4'h0, lk[LK_APP_LOW]);
            repeat (PC + 3) @(posedge sys_clk);
            bus(1'b1, REG_CTRL, 32'h1);
            st(SK_ERASE, LP, rL(), 4'h0, lk[LK_LDR_LOW]);
            repeat (PC + 3) @(posedge sys_clk);
        end
        $display("test lock modes done");
        st(SK_LOCKSET, LP, rA(), 4'h5, 1'b1);
        rd(REG_STATUS, 32'h50, "lockSet");
        st(SK_LOCKSET, rA(), rA(), 4'h0, 1'b0);
        lockw(4'hF);
        $display("test lock set done");
        rd(REG_IRQ_STAT, 32'h7, "irqAll");
        bus(1'b1, REG_IRQ_STAT, 32'h7);
        bus(1'b1, REG_IRQ_MASK, 32'h2);
        rd(REG_IRQ_MASK, 32'h2, "irqMask");
        st(SK_BUFFER, rA(), rA(), 4'h0, 1'b0);
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("irq", 1, irq);
        rd(REG_IRQ_STAT, 32'h2, "irqStat");
        bus(1'b1, REG_IRQ_STAT, 32'h2);
        @(negedge sys_clk);
        chk("irqClr", 0, irq);
        bus(1'b1, REG_IRQ_MASK, 32'h0);
        st(SK_BUFFER, rA(), rA(), 4'h0, 1'b0);
        repeat (2) @(posedge sys_clk);
        chk("irqMasked", 0, irq);
        rd(REG_IRQ_STAT, 32'h2, "irqStat2");
        $display("test interrupt done");
        repeat (4) @(posedge sys_clk);
        chk("pending", 0, 32'(stQ.size() + ldQ.size()));
        report_and_stop;
    end
endmodule : tb_top
